/* File: hdl/bme_pkg.sv */
package bme_pkg;

    localparam logic [7:0]  OPC_BIT_CLR_SET      = 8'h77;
    localparam logic [7:0]  OPC_BIT_OR           = 8'h07;
    localparam logic [7:0]  OPC_BRANCH_BIT_CLR   = 8'h37;

    localparam logic [3:0]  CYC_BIT_CLR_SET      = 4'h4;
    localparam logic [3:0]  CYC_BIT_OR           = 4'h6;
    localparam logic [3:0]  CYC_BRANCH           = 4'hA;
    localparam logic [3:0]  CYC_UNKNOWN          = 4'h1;

    localparam logic [15:0] LEN_TWO_BYTES        = 16'h0002;
    localparam logic [15:0] LEN_THREE_BYTES      = 16'h0003;

    localparam logic [7:0]  FLAGS_ADDR           = 8'hD5;
    localparam int          FLAG_POS_Z           = 6;
    localparam int          FLAG_POS_S           = 5;

    localparam int          FLD_WREG_MSB         = 7;
    localparam int          FLD_WREG_LSB         = 4;
    localparam int          FLD_BIT_MSB          = 3;
    localparam int          FLD_BIT_LSB          = 1;
    localparam int          FLD_DIR_POS          = 0;

    localparam logic [7:0]  REG_RESET            = 8'h00;
    localparam logic [15:0] PC_RESET             = 16'h0000;

    typedef enum logic [2:0] {
        KIND_NONE,
        KIND_BIT_CLR,
        KIND_BIT_SET,
        KIND_BIT_OR,
        KIND_BRANCH
    } bme_kind_t;

    typedef struct packed {
        logic [7:0] opcode;
        logic [7:0] fields;
        logic [7:0] extra;
    } bme_instr_t;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } bme_bus_t;

    typedef struct packed {
        logic       en;
        logic [7:0] addr;
        logic [7:0] data;
    } bme_wr_t;

    function automatic bme_kind_t bme_decode(input logic [7:0] opc, input logic dir);
        bme_kind_t k;
        k = KIND_NONE;
        case (opc)
            OPC_BIT_CLR_SET:    k = dir ? KIND_BIT_SET : KIND_BIT_CLR;
            OPC_BIT_OR:         k = KIND_BIT_OR;
            OPC_BRANCH_BIT_CLR: k = dir ? KIND_NONE : KIND_BRANCH;
            default:            k = KIND_NONE;
        endcase
        return k;
    endfunction : bme_decode

endpackage : bme_pkg

/* File: hdl/bme_regfile.sv */
`timescale 1ns/1ns
`default_nettype none
module bme_regfile
    import bme_pkg::*;
(
    input  wire logic       clock,
    input  wire logic       rst_n,
    input  wire logic [7:0] rdAddrA,
    input  wire logic [7:0] rdAddrB,
    output logic      [7:0] rdDataA,
    output logic      [7:0] rdDataB,
    output logic      [7:0] flagsData,
    input  wire bme_wr_t    execWr,
    input  wire bme_wr_t    flagWr,
    input  wire bme_bus_t   bus,
    output logic      [7:0] busRdata
);

    logic [7:0] mem [256];
    logic [7:0] busRdata_q;

    assign rdDataA   = mem[rdAddrA];
    assign rdDataB   = mem[rdAddrB];
    assign flagsData = mem[FLAGS_ADDR];
    assign busRdata  = busRdata_q;

    // later writes win: flags over a result in the same byte, software over both
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            for (int i = 0; i < 256; i++) begin
                mem[i] <= REG_RESET;
            end
            busRdata_q <= REG_RESET;
        end else begin
            if (execWr.en) begin
                mem[execWr.addr] <= execWr.data;
            end
            if (flagWr.en) begin
                mem[flagWr.addr] <= flagWr.data;
            end
            if (bus.wr) begin
                mem[bus.addr] <= bus.wdata;
            end
            busRdata_q <= bus.rd ? mem[bus.addr] : REG_RESET;
        end
    end

endmodule : bme_regfile
`default_nettype wire

/* File: hdl/bme_bitexec.sv */
`timescale 1ns/1ns
`default_nettype none
module bme_bitexec
    import bme_pkg::*;
(
    input  wire bme_kind_t  kind,
    input  wire logic [7:0] wregVal,
    input  wire logic [7:0] regVal,
    input  wire logic [2:0] bitIdx,
    input  wire logic       dir,
    input  wire logic [7:0] flagsIn,
    output logic            destWrite,
    output logic            destIsWreg,
    output logic      [7:0] destData,
    output logic            flagsWrite,
    output logic      [7:0] flagsOut,
    output logic            branchTaken
);

    logic orBit;

    always_comb begin
        destWrite   = 1'b0;
        destIsWreg  = 1'b1;
        destData    = wregVal;
        flagsWrite  = 1'b0;
        flagsOut    = flagsIn;
        branchTaken = 1'b0;
        orBit       = wregVal[0] | regVal[bitIdx];
        case (kind)
            KIND_BIT_CLR: begin
                destWrite        = 1'b1;
                destData[bitIdx] = 1'b0;
            end
            KIND_BIT_SET: begin
                destWrite        = 1'b1;
                destData[bitIdx] = 1'b1;
            end
            KIND_BIT_OR: begin
                destWrite = 1'b1;
                if (dir) begin
                    destIsWreg       = 1'b0;
                    destData         = regVal;
                    destData[bitIdx] = orBit;
                end else begin
                    destData[0] = orBit;
                end
                flagsWrite           = 1'b1;
                flagsOut[FLAG_POS_Z] = ~orBit;
                flagsOut[FLAG_POS_S] = 1'b0;
            end
            KIND_BRANCH: begin
                branchTaken = ~wregVal[bitIdx];
            end
            default: begin
                destWrite = 1'b0;
            end
        endcase
    end

endmodule : bme_bitexec
`default_nettype wire

/* File: hdl/bme_core.sv */
// How it works
// - Bit clear forces the chosen bit of the working register to 0 and touches no flag.
// - Bit set forces the chosen bit of the working register to 1 and touches no flag.
// - Opcode 77 is clear or set; byte two is register nibble, bit index, then select bit.
// - Bit clear and bit set are two bytes long and take four cycles.
// - Bit OR writes only the target bit, from working bit 0 ORed with a register bit.
// - Bit OR sets Z when the result is 0, clears S, and keeps C, D and H.
// - Bit OR is opcode 07, three bytes, six cycles; direction 1 targets the chosen bit of the register addressed by byte three.
// - Branch on bit clear adds the displacement when the tested bit is 0, no flag changes.
// - Branch on bit clear is opcode 37 with select bit 0, three bytes, ten cycles.
// - The flags that bit OR updates live in the register at address D5.
`timescale 1ns/1ns
`default_nettype none
module bme_core
    import bme_pkg::*;
(
    input  wire logic        clock,
    input  wire logic        rst_n,
    input  wire bme_bus_t    bus,
    output logic      [7:0]  busRdata,
    input  wire logic [3:0]  rpBase,
    input  wire logic        instrValid,
    input  wire bme_instr_t  instr,
    input  wire logic [15:0] instrPc,
    output logic             instrReady,
    output logic             done,
    output logic      [15:0] nextPc,
    output logic             branchTaken,
    output logic             unknownOp
);

    typedef enum logic {PH_IDLE, PH_EXEC} bme_phase_t;

    typedef struct packed {
        bme_phase_t  phase;
        logic [3:0]  count;
        bme_kind_t   kind;
        bme_instr_t  instr;
        logic [15:0] pc;
        logic        done;
        logic [15:0] nextPc;
        logic        taken;
        logic        unknown;
    } bme_state_t;

    bme_state_t s_q;
    bme_state_t s_d;

    logic [7:0] wregAddr;
    logic [7:0] wregVal;
    logic [7:0] regVal;
    logic [7:0] flagsVal;
    logic       destWrite;
    logic       destIsWreg;
    logic [7:0] destData;
    logic       flagsWrite;
    logic [7:0] flagsNew;
    logic       takenNow;
    logic       lastCycle;
    bme_wr_t    execWr;
    bme_wr_t    flagWr;

    // working registers sit in the 16-byte window chosen by rpBase
    assign wregAddr  = {rpBase, s_q.instr.fields[FLD_WREG_MSB:FLD_WREG_LSB]};
    assign lastCycle = (s_q.phase == PH_EXEC) && (s_q.count == 4'h0);

    bme_regfile u_regfile (
        .clock     (clock),
        .rst_n     (rst_n),
        .rdAddrA   (wregAddr),
        .rdAddrB   (s_q.instr.extra),
        .rdDataA   (wregVal),
        .rdDataB   (regVal),
        .flagsData (flagsVal),
        .execWr    (execWr),
        .flagWr    (flagWr),
        .bus       (bus),
        .busRdata  (busRdata)
    );

    bme_bitexec u_bitexec (
        .kind        (s_q.kind),
        .wregVal     (wregVal),
        .regVal      (regVal),
        .bitIdx      (s_q.instr.fields[FLD_BIT_MSB:FLD_BIT_LSB]),
        .dir         (s_q.instr.fields[FLD_DIR_POS]),
        .flagsIn     (flagsVal),
        .destWrite   (destWrite),
        .destIsWreg  (destIsWreg),
        .destData    (destData),
        .flagsWrite  (flagsWrite),
        .flagsOut    (flagsNew),
        .branchTaken (takenNow)
    );

    // results land only on the closing edge, so operands are sampled once
    always_comb begin
        execWr.en   = lastCycle && destWrite;
        execWr.addr = destIsWreg ? wregAddr : s_q.instr.extra;
        execWr.data = destData;
        flagWr.en   = lastCycle && flagsWrite;
        flagWr.addr = FLAGS_ADDR;
        flagWr.data = flagsNew;
    end

    assign instrReady  = (s_q.phase == PH_IDLE);
    assign done        = s_q.done;
    assign nextPc      = s_q.nextPc;
    assign branchTaken = s_q.taken;
    assign unknownOp   = s_q.unknown;

    always_comb begin
        s_d         = s_q;
        s_d.done    = 1'b0;
        s_d.taken   = 1'b0;
        s_d.unknown = 1'b0;
        case (s_q.phase)
            PH_IDLE: begin
                if (instrValid) begin
                    s_d.phase = PH_EXEC;
                    s_d.instr = instr;
                    s_d.pc    = instrPc;
                    s_d.kind  = bme_decode(instr.opcode, instr.fields[FLD_DIR_POS]);
                    case (s_d.kind)
                        KIND_BIT_CLR, KIND_BIT_SET: s_d.count = CYC_BIT_CLR_SET - 4'h1;
                        KIND_BIT_OR:                s_d.count = CYC_BIT_OR - 4'h1;
                        KIND_BRANCH:                s_d.count = CYC_BRANCH - 4'h1;
                        default:                    s_d.count = CYC_UNKNOWN - 4'h1;
                    endcase
                end
            end
            PH_EXEC: begin
                if (s_q.count == 4'h0) begin
                    s_d.phase = PH_IDLE;
                    s_d.done  = 1'b1;
                    case (s_q.kind)
                        KIND_BIT_CLR, KIND_BIT_SET: begin
                            s_d.nextPc = s_q.pc + LEN_TWO_BYTES;
                        end
                        KIND_BRANCH: begin
                            s_d.taken  = takenNow;
                            // a wrap past 64K follows plain modulo arithmetic
                            s_d.nextPc = s_q.pc + LEN_THREE_BYTES
                                + (takenNow ? {{8{s_q.instr.extra[7]}}, s_q.instr.extra}
                                            : 16'h0000);
                        end
                        KIND_BIT_OR: begin
                            s_d.nextPc = s_q.pc + LEN_THREE_BYTES;
                        end
                        default: begin
                            s_d.unknown = 1'b1;
                            s_d.nextPc  = s_q.pc;
                        end
                    endcase
                end else begin
                    s_d.count = s_q.count - 4'h1;
                end
            end
            default: begin
                s_d.phase = PH_IDLE;
            end
        endcase
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            s_q.phase   <= PH_IDLE;
            s_q.count   <= 4'h0;
            s_q.kind    <= KIND_NONE;
            s_q.instr   <= '0;
            s_q.pc      <= PC_RESET;
            s_q.done    <= 1'b0;
            s_q.nextPc  <= PC_RESET;
            s_q.taken   <= 1'b0;
            s_q.unknown <= 1'b0;
        end else begin
            s_q <= s_d;
        end
    end

endmodule : bme_core
`default_nettype wire

/* File: sim/bme_core_assertions.sv */
`timescale 1ns/1ns
`default_nettype none
module bme_core_assertions
    import bme_pkg::*;
(
    input wire logic        clock,
    input wire logic        rst_n,
    input wire logic        instrValid,
    input wire bme_instr_t  instr,
    input wire logic [15:0] instrPc,
    input wire logic        instrReady,
    input wire logic        done,
    input wire logic [15:0] nextPc,
    input wire logic        branchTaken,
    input wire logic        unknownOp
);
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);
    logic        take;
    logic        isBr;
    logic        isUnk;
    logic [15:0] brPc;
    assign take = instrValid && instrReady;
    assign isBr = instr.opcode == OPC_BRANCH_BIT_CLR && !instr.fields[0];
    assign isUnk = instr.opcode != OPC_BIT_CLR_SET && instr.opcode != OPC_BIT_OR && !isBr;
    // offset counts from the byte after the branch
    assign brPc = instrPc + 16'h0003 + {{8{instr.extra[7]}}, instr.extra};
    a_clrset_timing: assert property (
        take && instr.opcode == OPC_BIT_CLR_SET |=> !done [*4] ##1
        (done && nextPc == $past(instrPc, 5) + 16'h0002)) else $error("clear/set timing");
    a_or_timing: assert property (
        take && instr.opcode == OPC_BIT_OR |=> !done [*6] ##1
        (done && nextPc == $past(instrPc, 7) + 16'h0003)) else $error("bit or timing");
    a_branch_timing: assert property (
        take && isBr |=> !done [*8] ##1 !done ##1 !done ##1 done) else $error("branch timing");
    a_branch_target: assert property (
        take && isBr |-> ##11 nextPc == (branchTaken ? $past(brPc, 11)
        : $past(instrPc, 11) + 16'h0003)) else $error("branch target");
    a_unknown_pulse: assert property (
        take && isUnk |=> !done ##1 (done && unknownOp && nextPc == $past(instrPc, 2)))
        else $error("unknown opcode");
    a_branch_flag: assert property (
        branchTaken |-> done && !unknownOp) else $error("stray branch flag");
    a_busy_after_take: assert property (
        take |=> !instrReady) else $error("ready while busy");
    a_done_single: assert property (
        done |=> !done) else $error("done too long");
    c_branch: cover property (take && isBr ##11 branchTaken);
    c_bitor: cover property (take && instr.opcode == OPC_BIT_OR);
    c_unknown: cover property (done && unknownOp);
endmodule : bme_core_assertions
bind bme_core bme_core_assertions u_chk (.clock(clock), .rst_n(rst_n),
    .instrValid(instrValid), .instr(instr), .instrPc(instrPc), .instrReady(instrReady),
    .done(done), .nextPc(nextPc), .branchTaken(branchTaken), .unknownOp(unknownOp));
`default_nettype wire

/* File: sim/bme_core_tb.sv */
`timescale 1ns/1ns
`default_nettype none
module bme_core_tb
    import bme_pkg::*;
;
    logic        clock;
    logic        rst_n = 1'b0;
    bme_bus_t    bus = '0;
    logic [7:0]  busRdata;
    logic [3:0]  rpBase = 4'h3;
    logic        instrValid = 1'b0;
    bme_instr_t  instr = '0;
    logic [15:0] instrPc = 16'h0000;
    logic        instrReady;
    logic        done;
    logic [15:0] nextPc;
    logic        branchTaken;
    logic        unknownOp;
    int          nMismatch = 0;
    int          checkCount = 0;
    int          cycles = 0;
    bme_core u_dut (.clock(clock), .rst_n(rst_n), .bus(bus), .busRdata(busRdata),
        .rpBase(rpBase), .instrValid(instrValid), .instr(instr), .instrPc(instrPc),
        .instrReady(instrReady), .done(done), .nextPc(nextPc),
        .branchTaken(branchTaken), .unknownOp(unknownOp));
    initial begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checkCount++;
        if (seen !== exp) begin
            nMismatch++;
            $display("[ERR] %0t got %h want %h", $time, seen, exp);
        end
    endtask : chk
    task automatic endOfTest();
        $display("checks %0d mismatches %0d", checkCount, nMismatch);
        if (nMismatch == 0 && checkCount > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : endOfTest
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock);
        bus <= {a, d, 2'b10};
        @(posedge clock);
        bus <= '0;
    endtask : wr
    task automatic rc(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clock);
        bus <= {a, 8'h00, 2'b01};
        @(posedge clock);
        bus <= '0;
        @(negedge clock);
        chk({8'h00, busRdata}, {8'h00, exp});
    endtask : rc
    // fl is {branch taken, unknown opcode} seen with done
    task automatic run(input logic [7:0] op, input logic [7:0] f, input logic [7:0] ex,
        input logic [15:0] pc, input logic [15:0] npc, input logic [1:0] fl);
        int n;
        @(posedge clock);
        instrValid <= 1'b1;
        instr <= {op, f, ex};
        instrPc <= pc;
        @(posedge clock);
        instrValid <= 1'b0;
        n = 0;
        do begin
            @(negedge clock);
            n++;
        end while (done !== 1'b1 && n < 20);
        chk(nextPc, npc);
        chk({12'h000, instrReady, done, branchTaken, unknownOp}, {12'h000, 2'b11, fl});
    endtask : run
    initial begin
        repeat (20) @(posedge clock);
        rst_n <= 1'b1;
        @(negedge clock);
        chk(nextPc, PC_RESET);
        chk({12'h000, instrReady, done, branchTaken, unknownOp}, 16'h0008);
        rc(FLAGS_ADDR, 8'h00);
        rc(8'hFF, REG_RESET);
        wr(FLAGS_ADDR, 8'hA5);
        for (int i = 0; i < 8; i++) begin
            wr({rpBase, 4'(i + 8)}, 8'h00);
            run(OPC_BIT_CLR_SET, {4'(i + 8), 3'(i), 1'b1}, 8'h00, 16'(i), 16'(i + 2), 2'b00);
            rc({rpBase, 4'(i + 8)}, 8'h01 << i);
        end
        wr(8'h31, 8'h07);
        run(OPC_BIT_CLR_SET, 8'h12, 8'h00, 16'hFFFF, 16'h0001, 2'b00);
        rc(8'h31, 8'h05);
        rc(FLAGS_ADDR, 8'hA5);
        @(posedge clock);
        rpBase <= 4'h1;
        // bit or, direction 0 then 1, result 1, 0, 1
        wr(8'h11, 8'h06);
        wr(8'h40, 8'h02);
        wr(FLAGS_ADDR, 8'hFF);
        run(OPC_BIT_OR, 8'h12, 8'h40, 16'h0200, 16'h0203, 2'b00);
        rc(8'h11, 8'h07);
        rc(8'h40, 8'h02);
        rc(FLAGS_ADDR, 8'h9F);
        wr(8'h11, 8'h06);
        wr(FLAGS_ADDR, 8'h20);
        run(OPC_BIT_OR, 8'h17, 8'h40, 16'hFFFE, 16'h0001, 2'b00);
        rc(8'h40, 8'h02);
        rc(FLAGS_ADDR, 8'h40);
        wr(8'h11, 8'h07);
        run(OPC_BIT_OR, 8'h15, 8'h40, 16'h0300, 16'h0303, 2'b00);
        rc(8'h40, 8'h06);
        rc(8'h11, 8'h07);
        rc(FLAGS_ADDR, 8'h00);
        wr(FLAGS_ADDR, 8'hE7);
        run(OPC_BRANCH_BIT_CLR, 8'h16, 8'h80, 16'h0100, 16'h0083, 2'b10);
        run(OPC_BRANCH_BIT_CLR, 8'h16, 8'h7F, 16'hFFF0, 16'h0072, 2'b10);
        run(OPC_BRANCH_BIT_CLR, 8'h14, 8'h7F, 16'h0400, 16'h0403, 2'b00);
        rc(FLAGS_ADDR, 8'hE7);
        run(OPC_BRANCH_BIT_CLR, 8'h15, 8'h10, 16'h0500, 16'h0500, 2'b01);
        run(8'h57, 8'h12, 8'h00, 16'h0600, 16'h0600, 2'b01);
        endOfTest();
    end
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            nMismatch++;
            endOfTest();
        end
    end
endmodule : bme_core_tb
`default_nettype wire
